/* core/pgc_pkg.sv */
// Purpose: constants for the pwm generator control and capture block
// Assumes: 16-bit register port, word index addressing
// Notes: register offsets beyond the two named registers are local choices
package pgc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int TB_W = 16;
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_CAPTURE = 4'h1;
  localparam logic [3:0] OFS_PDUTY = 4'h2;
  localparam logic [3:0] OFS_SDUTY = 4'h3;
  localparam logic [3:0] OFS_MDUTY = 4'h4;
  localparam logic [3:0] OFS_PPHASE = 4'h5;
  localparam logic [3:0] OFS_MPERIOD = 4'h6;
  localparam logic [3:0] OFS_DEADTIME = 4'h7;
  localparam logic [3:0] OFS_EVENTS = 4'h8;
  localparam logic [3:0] OFS_ACTIVE_DUTY = 4'h9;
  localparam int B_FAULT_PEND = 15;
  localparam int B_LIMIT_PEND = 14;
  localparam int B_TRIG_PEND = 13;
  localparam int B_FAULT_EN = 12;
  localparam int B_LIMIT_EN = 11;
  localparam int B_TRIG_EN = 10;
  localparam int B_ITB = 9;
  localparam int B_MDS = 8;
  localparam int B_DT_HI = 7;
  localparam int B_DT_LO = 6;
  localparam int B_CPOL = 5;
  localparam int B_TBSEL = 3;
  localparam int B_CAM = 2;
  localparam int B_XRES = 1;
  localparam int B_IUE = 0;
  localparam logic [15:0] CONTROL_WMASK = 16'h1FEF;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int CAP_LSB = 3;
  localparam logic [2:0] CAM_MASK_ZERO = 3'h0;
  localparam int LEB_CYCLES = 4;
  localparam real CAP_RES_NS = 8.32;
  localparam real CLK_NS = 50.0;
  // capture granularity is one clock, coarser than the 8.32 ns resolution figure
  localparam int CAP_RES_CYC = (CAP_RES_NS / CLK_NS) < 1.0 ? 1 : int'(CAP_RES_NS / CLK_NS);
  typedef enum logic [1:0] {
    PGC_DT_POS,
    PGC_DT_NEG,
    PGC_DT_OFF,
    PGC_DT_COMP
  } pgc_dt_t;
endpackage : pgc_pkg

/* core/pgc_sync.sv */
// Purpose: two-flop synchroniser for a pin input
// Assumes: input is asynchronous to clk
// Notes: first stage read only by the second
`timescale 1ns/1ps
module pgc_sync (
  input wire logic clk, // clock
  input wire logic sys_rst, // async reset
  input wire logic din, // raw pin
  output logic dout // synchronised level
);
  logic stage1;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : pgc_sync

/* core/pgc_blank.sv */
// Purpose: leading-edge blanking of the current-limit level
// Assumes: input already synchronised
// Notes: a rise must hold for the blanking count before it counts as an edge
`timescale 1ns/1ps
module pgc_blank #(
  parameter int BLANK = pgc_pkg::LEB_CYCLES
) (
  input wire logic clk, // clock
  input wire logic sys_rst, // async reset
  input wire logic lvl, // synchronised limit level
  output logic edgeOut // one-cycle qualified leading edge
);
  import pgc_pkg::*;
  logic [7:0] cnt;
  logic armed;
  wire atEnd = (cnt == 8'(BLANK));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 8'h00;
      armed <= 1'b1;
      edgeOut <= 1'b0;
    end else begin
      edgeOut <= 1'b0;
      if (!lvl) begin
        cnt <= 8'h00;
        armed <= 1'b1;
      end else if (armed && !atEnd) begin
        cnt <= cnt + 8'h01;
      end else if (armed) begin
        edgeOut <= 1'b1;
        armed <= 1'b0;
      end
    end
  end
endmodule : pgc_blank

/* core/pgc_gen.sv */
// Purpose: per-generator control register, time base, duty select, dead time, capture
// Assumes: pins sync'ed internally; master time bases come from same clock
// Notes: outputs registered; dead time counted in clocks
`timescale 1ns/1ps
module pgc_gen #(
  parameter int BLANK = pgc_pkg::LEB_CYCLES
) (
  input wire logic clk, // 20 MHz clock
  input wire logic sys_rst, // async reset, high
  input wire logic [pgc_pkg::ADDR_W-1:0] addr, // register index
  input wire logic [pgc_pkg::DATA_W-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [pgc_pkg::DATA_W-1:0] rdata, // read data, cycle after rd
  input wire logic limitPin, // current-limit input pin
  input wire logic compensationInput, // compensation input pin
  input wire logic faultEvent, // fault event, same clock
  input wire logic triggerEvent, // trigger event, same clock
  input wire logic primarySync, // primary master period start
  input wire logic secondarySync, // secondary master period start
  input wire logic secondaryAvail, // secondary base exists
  output logic highSideOutput, // high-side drive
  output logic lowSideOutput, // low-side drive
  output logic faultIrq, // fault request level
  output logic limitIrq, // limit request level
  output logic triggerIrq // trigger request level
);
  import pgc_pkg::*;

  logic [15:0] control, pDuty, sDuty, mDuty, pPhase, mPeriod, deadTime;
  logic [15:0] activeP, activeS, activeM, capture, tb;
  logic [15:0] next_tb;
  logic limitLvl, limitEdge, compLvl, tbUp, rawH;
  logic [7:0] dtCnt;
  logic outH, outL, prevRaw;

  pgc_sync uSyncLim (.clk(clk), .sys_rst(sys_rst), .din(limitPin), .dout(limitLvl));
  pgc_sync uSyncCmp (.clk(clk), .sys_rst(sys_rst), .din(compensationInput), .dout(compLvl));
  pgc_blank #(.BLANK(BLANK)) uBlank (.clk(clk), .sys_rst(sys_rst), .lvl(limitLvl), .edgeOut(limitEdge));

  // mode decode
  wire independent_timebase = control[B_ITB];
  wire center_aligned_enable = control[B_CAM] & independent_timebase;
  wire [1:0] dtMode = control[B_DT_HI:B_DT_LO];
  wire cpolEff = (dtMode == 2'(PGC_DT_COMP)) & control[B_CPOL];
  wire useSec = control[B_TBSEL] & secondaryAvail;
  wire masterSync = useSec ? secondarySync : primarySync;
  wire xReset = control[B_XRES] & independent_timebase & limitEdge;
  // only the limit source can reset the base, and only when enabled
  wire [15:0] period = independent_timebase ? pPhase : mPeriod;
  wire [15:0] camMask = center_aligned_enable ? {13'h1FFF, CAM_MASK_ZERO} : 16'hFFFF;
  wire [15:0] dutySel = control[B_MDS] ? activeM : activeP;
  wire [15:0] dutyEff = dutySel & camMask;
  wire [15:0] perEff = period & camMask;
  wire [15:0] dtEff = deadTime & camMask;
  wire tbWrap = independent_timebase ? (tb >= perEff) : masterSync;
  wire periodStart = tbWrap | xReset;

  wire selCtl = addr == OFS_CONTROL;
  wire ctlWr = wr & selCtl;
  // a write of one clears a pending flag; a new event that cycle still wins
  wire [2:0] evt = {faultEvent, limitEdge, triggerEvent};
  wire [2:0] ens = {control[B_FAULT_EN], control[B_LIMIT_EN], control[B_TRIG_EN]};
  wire [2:0] pend = control[B_FAULT_PEND:B_TRIG_PEND];
  wire [2:0] clr = ctlWr ? wdata[B_FAULT_PEND:B_TRIG_PEND] : 3'h0;
  wire [2:0] ensNext = ctlWr ? wdata[B_FAULT_EN:B_TRIG_EN] : ens;
  // disabling an enable clears its flag
  wire [2:0] pendNext = ((pend & ~clr) | (evt & ensNext)) & ensNext;
  wire [15:0] ctlLow = ctlWr ? (wdata & CONTROL_WMASK) : (control & CONTROL_WMASK);
  wire [15:0] next_control = {pendNext, ctlLow[12:0]};

  // centre and edge mode both count up; the wrap at the period wins over the turn
  logic down;
  always_comb begin
    next_tb = tb + 16'h0001;
    if (periodStart) next_tb = 16'h0000;
    else if (center_aligned_enable && down) next_tb = tb - 16'h0001;
  end
  wire dirFlip = center_aligned_enable & (independent_timebase ? (tb >= perEff) : 1'b0);

  // duty comparison; in centre mode the pulse sits at the end of the count, before the wrap
  wire rawHigh = center_aligned_enable ? (tb >= (perEff - dutyEff)) : (tb < dutyEff);

  // compensation: which side to trim by the dead-time figure
  wire shortenLow = cpolEff ? ~compLvl : compLvl;
  wire dtOn = (dtMode != 2'(PGC_DT_OFF));
  // band opens with the change itself, so no one-clock spike leads it
  wire inBand = (rawHigh != prevRaw) ? (dtOn & (dtEff[7:0] != 8'h00)) : (dtCnt > 8'h01);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      control <= CONTROL_RESET;
      {pDuty, sDuty, mDuty} <= {3{REG_RESET}};
      {pPhase, mPeriod, deadTime} <= {3{REG_RESET}};
      {activeP, activeS, activeM} <= {3{REG_RESET}};
    end else begin
      control <= next_control;
      if (wr && addr == OFS_PDUTY) pDuty <= wdata;
      if (wr && addr == OFS_SDUTY) sDuty <= wdata;
      if (wr && addr == OFS_MDUTY) mDuty <= wdata;
      if (wr && addr == OFS_PPHASE) pPhase <= wdata;
      if (wr && addr == OFS_MPERIOD) mPeriod <= wdata;
      if (wr && addr == OFS_DEADTIME) deadTime <= wdata;
      if (control[B_IUE]) begin
        activeP <= pDuty;
        activeS <= sDuty;
        activeM <= mDuty;
      end else if (periodStart) begin
        activeP <= pDuty;
        activeS <= sDuty;
        activeM <= mDuty;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tb <= 16'h0000;
      down <= 1'b0;
      capture <= 16'h0000;
    end else begin
      tb <= next_tb;
      down <= periodStart ? 1'b0 : (dirFlip ? 1'b1 : down);
      // capture of the time base, per clock granularity
      if (limitEdge) capture <= {tb[12:0], 3'h0};
    end
  end

  // dead-time shaping of the complementary pair
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prevRaw <= 1'b0;
      dtCnt <= 8'h00;
      outH <= 1'b0;
      outL <= 1'b0;
    end else begin
      prevRaw <= rawHigh;
      if (rawHigh != prevRaw) dtCnt <= dtOn ? dtEff[7:0] : 8'h00;
      else if (dtCnt != 8'h00) dtCnt <= dtCnt - 8'h01;
      case (dtMode)
        2'(PGC_DT_OFF): begin
          outH <= rawHigh;
          outL <= ~rawHigh;
        end
        2'(PGC_DT_NEG): begin
          // overlap during the dead band
          outH <= rawHigh | inBand;
          outL <= ~rawHigh | inBand;
        end
        2'(PGC_DT_COMP): begin
          outH <= shortenLow ? (rawHigh | inBand) : (rawHigh & ~inBand);
          outL <= shortenLow ? (~rawHigh & ~inBand) : (~rawHigh | inBand);
        end
        default: begin
          outH <= rawHigh & ~inBand;
          outL <= ~rawHigh & ~inBand;
        end
      endcase
    end
  end

  assign rawH = outH;
  assign highSideOutput = rawH;
  assign lowSideOutput = outL;
  assign faultIrq = control[B_FAULT_PEND];
  assign limitIrq = control[B_LIMIT_PEND];
  assign triggerIrq = control[B_TRIG_PEND];

  // read mux
  logic [15:0] rsel;
  always_comb begin
    case (addr)
      OFS_CONTROL: rsel = control;
      OFS_CAPTURE: rsel = capture;
      OFS_PDUTY: rsel = pDuty;
      OFS_SDUTY: rsel = sDuty;
      OFS_MDUTY: rsel = mDuty;
      OFS_PPHASE: rsel = pPhase;
      OFS_MPERIOD: rsel = mPeriod;
      OFS_DEADTIME: rsel = deadTime;
      OFS_EVENTS: rsel = tb;
      OFS_ACTIVE_DUTY: rsel = dutyEff;
      default: rsel = 16'h0000;
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rdata <= 16'h0000;
    else rdata <= rd ? rsel : 16'h0000;
  end
  logic unusedS;
  assign unusedS = |activeS;
endmodule : pgc_gen

/* test/pgc_chk.sv */
// Purpose: port assertions for pgc_gen
// Assumes: one clock domain, enables shadowed from control writes
// Notes: flag and read-data relations; pin timing is left to the bench
`timescale 1ns/1ps
module pgc_chk (
  input logic clk, // clock
  input logic sys_rst, // reset
  input logic [pgc_pkg::ADDR_W-1:0] addr, // index
  input logic [pgc_pkg::DATA_W-1:0] wdata, // write data
  input logic wr, // write strobe
  input logic rd, // read strobe
  input logic [pgc_pkg::DATA_W-1:0] rdata, // read data
  input logic faultEvent, // fault pulse
  input logic triggerEvent, // trigger pulse
  input logic faultIrq, // fault flag
  input logic triggerIrq // trigger flag
);
  import pgc_pkg::*;
  logic fEn;
  logic tEn;
  wire ctlWr = wr && addr == OFS_CONTROL;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fEn <= 1'b0;
      tEn <= 1'b0;
    end else if (ctlWr) begin
      fEn <= wdata[B_FAULT_EN];
      tEn <= wdata[B_TRIG_EN];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_read_idle: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("rdata not zero");
  chk_cap_low: assert property ($past(rd) && $past(addr) == OFS_CAPTURE |-> rdata[2:0] == 3'h0)
    else $error("capture low bits set");
  chk_unmapped_zero: assert property ($past(rd) && $past(addr) > OFS_ACTIVE_DUTY |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_ctl_mirror: assert property ($past(rd) && $past(addr) == OFS_CONTROL |-> !rdata[4] && rdata[15] == $past(faultIrq))
    else $error("control read wrong");
  chk_fault_set: assert property (faultEvent && fEn && !ctlWr |=> faultIrq)
    else $error("fault flag not set");
  chk_fault_quiet: assert property (!fEn && !faultIrq |=> !faultIrq) else $error("fault flag while off");
  chk_fault_clear: assert property (ctlWr && wdata[B_FAULT_PEND] && !faultEvent |=> !faultIrq)
    else $error("fault flag not cleared");
  chk_trig_hold: assert property (triggerIrq && !ctlWr |=> triggerIrq)
    else $error("trigger flag dropped");
  chk_trig_set: assert property (triggerEvent && tEn && !ctlWr |=> triggerIrq) else $error("trigger not set");
  cover property (faultEvent && fEn);
  cover property (triggerIrq);
  cover property ($past(rd) && $past(addr) == OFS_CAPTURE && rdata != 16'h0000);
endmodule : pgc_chk
bind pgc_gen pgc_chk u_chk (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .faultEvent(faultEvent), .triggerEvent(triggerEvent), .faultIrq(faultIrq),
  .triggerIrq(triggerIrq));

/* test/pgc_stage.sv */
// Purpose: current-limit sensing and compensation source model
// Assumes: pulses are counted in clocks
// Notes: limit line idles low between pulses
`timescale 1ns/1ps
module pgc_stage (
  input logic clk, // clock
  input logic go, // start a limit pulse
  input logic [7:0] pulseLen, // pulse length in clocks
  input logic compLevel, // compensation level
  output logic limitPin, // current-limit sense
  output logic compensationInput // compensation sense
);
  logic [7:0] left = 8'h00;
  always @(posedge clk) begin
    if (go) left <= pulseLen;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  assign limitPin = left != 8'h00;
  assign compensationInput = compLevel;
endmodule : pgc_stage

/* test/test_pgc_gen.sv */
// Purpose: self-checking bench for pgc_gen
// Assumes: reads sampled half a cycle after the data edge
// Notes: sync inputs pulsed by hand; period kept long so no wrap hits duty checks
`timescale 1ns/1ps
module test_pgc_gen;
  import pgc_pkg::*;
  typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} pgc_row_t;
  logic clk = 0, sys_rst = 1, wr = 0, rd = 0, fEv = 0, tEv = 0, go = 0, limitPin, comp;
  logic hi, lo, fIrq, lIrq, tIrq;
  logic pS = 0, sS = 0, sAv = 0, cLvl = 0;
  logic [3:0] addr = 0;
  logic [15:0] wdata = 0, rdata, v;
  logic [7:0] plen = 0;
  int errorCnt = 0, nChecks = 0, cycles = 0, i;
  pgc_row_t rows [10] = '{'{OFS_PDUTY, 16'h1234, 16'h1234}, '{OFS_SDUTY, 16'hA5A5, 16'hA5A5},
    '{OFS_MDUTY, 16'h5A5A, 16'h5A5A}, '{OFS_PPHASE, 16'h0FF0, 16'h0FF0}, '{OFS_DEADTIME, 16'h0013, 16'h0013},
    '{OFS_MPERIOD, 16'h7FFF, 16'h7FFF}, '{OFS_CAPTURE, 16'hFFFF, 16'h0000}, '{4'hA, 16'hFFFF, 16'h0000},
    '{OFS_CONTROL, 16'hFFFF, CONTROL_WMASK}, '{OFS_CONTROL, 16'h0000, 16'h0000}};
  always #25 clk = ~clk;
  pgc_stage u_stage (.clk(clk), .go(go), .pulseLen(plen), .compLevel(cLvl), .limitPin(limitPin),
    .compensationInput(comp));
  pgc_gen DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .limitPin(limitPin), .compensationInput(comp), .faultEvent(fEv), .triggerEvent(tEv),
    .primarySync(pS), .secondarySync(sS), .secondaryAvail(sAv), .highSideOutput(hi),
    .lowSideOutput(lo), .faultIrq(fIrq), .limitIrq(lIrq), .triggerIrq(tIrq));
  task end_of_test;
    if (errorCnt == 0 && nChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [3:0] a);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) v = rdata;
  endtask : rreg
  task limitPulse(input logic [7:0] n);
    @(posedge clk) {go, plen} <= {1'b1, n};
    @(posedge clk) go <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : limitPulse
  task syncPulse(input logic p, input logic s);
    @(posedge clk) {pS, sS} <= {p, s};
    @(posedge clk) {pS, sS} <= 2'b00;
  endtask : syncPulse
  task outCase(input logic [15:0] ctl, input logic c, input logic [15:0] eh, input logic [15:0] el);
    logic [15:0] nh;
    logic [15:0] nl;
    @(posedge clk) cLvl <= c;
    wreg(OFS_CONTROL, ctl);
    // two periods to settle, then four whole periods counted
    repeat (32) @(posedge clk);
    nh = 16'h0000;
    nl = 16'h0000;
    repeat (64) begin
      @(negedge clk);
      nh = nh + 16'(hi);
      nl = nl + 16'(lo);
    end
    check("high time", nh, eh);
    check("low time", nl, el);
  endtask : outCase
  task dutyCase(input logic [15:0] ctl, input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
    wreg(OFS_CONTROL, ctl);
    wreg(a, d);
    rreg(OFS_ACTIVE_DUTY);
    check("active duty", v, e);
  endtask : dutyCase
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errorCnt++;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 10; i++) begin
      wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a);
      check("register", v, rows[i].e);
    end
    for (i = 0; i < 4; i++) begin
      wreg(OFS_CONTROL, (16'(i) << B_DT_LO) | 16'h0020);
      rreg(OFS_CONTROL);
      check("deadtime code", v, (16'(i) << B_DT_LO) | 16'h0020);
    end
    for (i = 0; i < 2; i++) begin
      wreg(OFS_CONTROL, 16'h0001 << (i ? B_TRIG_EN : B_FAULT_EN));
      @(posedge clk) {fEv, tEv} <= {i == 0, i == 1};
      @(posedge clk) {fEv, tEv} <= 2'b00;
      rreg(OFS_CONTROL);
      check("flag set", 16'(v[i ? B_TRIG_PEND : B_FAULT_PEND]), 16'h0001);
      check("flag line", 16'(i ? tIrq : fIrq), 16'h0001);
      wreg(OFS_CONTROL, v);
      rreg(OFS_CONTROL);
      check("flag clear", 16'(v[i ? B_TRIG_PEND : B_FAULT_PEND]), 16'h0000);
    end
    wreg(OFS_CONTROL, 16'h0800);
    limitPulse(8'h02);
    rreg(OFS_CAPTURE);
    check("blanked capture", v, 16'h0000);
    check("blanked flag", 16'(lIrq), 16'h0000);
    limitPulse(8'h0C);
    rreg(OFS_CAPTURE);
    check("capture taken", 16'(v != 16'h0000), 16'h0001);
    check("limit flag", 16'(lIrq), 16'h0001);
    dutyCase(16'h0001, OFS_PDUTY, 16'h0444, 16'h0444);
    dutyCase(16'h0000, OFS_PDUTY, 16'h0555, 16'h0444);
    dutyCase(16'h0101, OFS_MDUTY, 16'h0666, 16'h0666);
    dutyCase(16'h0005, OFS_PDUTY, 16'h1237, 16'h1237);
    dutyCase(16'h0205, OFS_PDUTY, 16'h1237, 16'h1230);
    @(posedge clk) sAv <= 1'b1;
    wreg(OFS_CONTROL, 16'h0008);
    wreg(OFS_PDUTY, 16'h0777);
    syncPulse(1'b1, 1'b0);
    rreg(OFS_ACTIVE_DUTY);
    check("primary ignored", v, 16'h1237);
    syncPulse(1'b0, 1'b1);
    rreg(OFS_ACTIVE_DUTY);
    check("secondary sync", v, 16'h0777);
    @(posedge clk) sAv <= 1'b0;
    wreg(OFS_PDUTY, 16'h0888);
    syncPulse(1'b1, 1'b0);
    rreg(OFS_ACTIVE_DUTY);
    check("primary sync", v, 16'h0888);
    wreg(OFS_PPHASE, 16'h7FF8);
    wreg(OFS_CONTROL, 16'h0200);
    wreg(OFS_PDUTY, 16'h0999);
    limitPulse(8'h0C);
    rreg(OFS_ACTIVE_DUTY);
    check("no external reset", v, 16'h0888);
    wreg(OFS_CONTROL, 16'h0202);
    limitPulse(8'h0C);
    rreg(OFS_ACTIVE_DUTY);
    check("external reset", v, 16'h0999);
    wreg(OFS_PPHASE, 16'h000F);
    wreg(OFS_PDUTY, 16'h0006);
    wreg(OFS_DEADTIME, 16'h0002);
    outCase(16'h0281, 1'b0, 16'h0018, 16'h0028);
    outCase(16'h0201, 1'b0, 16'h0010, 16'h0020);
    outCase(16'h0241, 1'b0, 16'h0020, 16'h0030);
    outCase(16'h02E1, 1'b0, 16'h0020, 16'h0020);
    outCase(16'h02E1, 1'b1, 16'h0010, 16'h0030);
    outCase(16'h02C1, 1'b0, 16'h0010, 16'h0030);
    outCase(16'h02C1, 1'b1, 16'h0020, 16'h0020);
    outCase(16'h0221, 1'b0, 16'h0010, 16'h0020);
    @(posedge clk) sys_rst <= 1'b1;
    @(posedge clk) sys_rst <= 1'b0;
    rreg(OFS_CONTROL);
    check("control reset", v, CONTROL_RESET);
    rreg(OFS_PDUTY);
    check("duty reset", v, REG_RESET);
    end_of_test;
  end
endmodule : test_pgc_gen
